//--- core/adc_port_pkg.sv
// shared constants and types for the serial converter port
package adc_port_pkg;

	// frame layout, counted in falling serial clock edges
	localparam int unsigned  RESULT_BITS     = 14;
	localparam int unsigned  SUB_BITS        = 2;
	localparam int unsigned  WORD_BITS       = RESULT_BITS + SUB_BITS;
	localparam logic [4:0]   LEAD_ZEROS      = 5'h08;
	localparam logic [4:0]   HOLD_EDGE       = 5'h06;
	localparam logic [4:0]   DATA_FIRST_EDGE = 5'h08;
	localparam logic [4:0]   DATA_LAST_EDGE  = 5'h17;
	localparam logic [4:0]   FRAME_EDGES     = 5'h18;

	// sample buffer
	localparam int unsigned  FIFO_DEPTH      = 32;

	// timing: system clock and the two figures checked against it
	localparam int unsigned  CLK_PERIOD_PS   = 5000;
	localparam int unsigned  ACQ_MIN_NS_X10  = 11;    // 1.1 us, in units of 100 ns
	localparam int unsigned  SCLK_MIN_PER_NS = 208;   // 4.8 MHz ceiling
	localparam int unsigned  ACQ_CYCLES_I    =
		(ACQ_MIN_NS_X10 * 100000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned  SCLK_CYCLES_I   =
		(SCLK_MIN_PER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [8:0]   ACQ_CYCLES      = ACQ_CYCLES_I[8:0];
	localparam logic [8:0]   SCLK_MIN_CYCLES = SCLK_CYCLES_I[8:0];

	// pin reset levels: select idles high, clock idles low
	localparam logic         CS_N_RESET      = 1'b1;
	localparam logic         SCLK_RESET      = 1'b0;

	// one held sample: result code and the two trailing sub-bits
	typedef struct packed {
		logic [RESULT_BITS-1:0] code;
		logic [SUB_BITS-1:0]    sub_bits;
	} sample_t;

	// conversion sequencer states
	typedef enum logic [1:0] {
		ST_SHUTDOWN = 2'b00,
		ST_ACQUIRE  = 2'b01,
		ST_CONVERT  = 2'b10,
		ST_TRAIL    = 2'b11
	} conv_state_t;

endpackage

//--- core/pin_sync.sv
// two flip-flop synchroniser for one asynchronous pin
`timescale 1ns/1ps
module pin_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	// clock and reset
	input  wire logic clock,
	input  wire logic nrst,
	// pin and synchronised level
	input  wire logic pin,
	output logic      level
);

	logic meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			meta_q <= RESET_VAL;
			level  <= RESET_VAL;
		end else begin
			meta_q <= pin;
			level  <= meta_q;
		end
	end

endmodule // pin_sync

//--- core/sample_fifo.sv
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module sample_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 32
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             nrst,
	// fill side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// drain side
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready
);

	localparam int unsigned AW = $clog2(DEPTH);
	localparam int unsigned CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] DEPTH_C = DEPTH[CW-1:0];

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_ptr_q;
	logic [AW-1:0]    rd_ptr_q;
	logic [CW-1:0]    count_q;
	logic [CW-1:0]    count_d;
	wire              push = in_valid & in_ready;
	wire              pop  = out_valid & out_ready;

	assign out_data = mem_q[rd_ptr_q];

	// flags are registered from the next count so both stay honest
	always_comb begin
		count_d = count_q;
		if (push && !pop)
			count_d = count_q + 1'b1;
		else if (pop && !push)
			count_d = count_q - 1'b1;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wr_ptr_q  <= '0;
			rd_ptr_q  <= '0;
			count_q   <= '0;
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			if (push)
				wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
			if (pop)
				rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
			count_q   <= count_d;
			in_ready  <= (count_d != DEPTH_C);
			out_valid <= (count_d != '0);
		end
	end

	// storage has no reset; only written slots are ever read
	always_ff @(posedge clock) begin
		if (push)
			mem_q[wr_ptr_q] <= in_data;
	end

endmodule // sample_fifo

//--- core/serial_adc_port.sv
// conversion sequencer and serial result port of a 14-bit converter
//
// What this block does
// - select high keeps the block in shutdown; only normal and shutdown exist.
// - select falling edge powers up and starts acquisition and conversion.
// - serial data changes only on falling serial clock edges.
// - serial data is high impedance while select is high.
// - every conversion yields a 14-bit result word.
// - frame sends eight zeros, then the result most significant bit first.
// - result is sent as plain unsigned binary.
// - sampling runs until the sixth clock falling edge, then the input is held.
// - a full frame is 24 falling edges: zeros, result, two sub-bits.
// - extra clocks after the frame shift zeros and leave the converter alone.
// - select rising early aborts the conversion at once, back to shutdown.
// - select falling edge enables the data output driving low.
`timescale 1ns/1ps
module serial_adc_port (
	// clock and reset
	input  wire logic                 clock,
	input  wire logic                 nrst,
	// serial pins, asynchronous to clock
	input  wire logic                 cs_n_pin,
	input  wire logic                 sclk_pin,
	output logic                      dout_o,
	output logic                      dout_oe,
	// digitised samples from the converter core
	input  wire logic                 sample_valid,
	input  adc_port_pkg::sample_t     sample_data,
	output logic                      sample_ready,
	// status levels and pulses
	output logic                      powered_up,
	output logic                      holding,
	output logic                      frame_done,
	output logic                      acq_short,
	output logic                      sclk_fast,
	output logic                      underrun
);

	import adc_port_pkg::*;

	// synchronised pin levels and their previous values
	logic                 cs_n_s;
	logic                 sclk_s;
	logic                 cs_n_prev_q;
	logic                 sclk_prev_q;

	// sequencer state
	conv_state_t          state_q;
	conv_state_t          state_d;
	logic [4:0]           edge_cnt_q;
	logic [WORD_BITS-1:0] shift_q;

	// timing supervision
	logic [8:0]           acq_cnt_q;
	logic [8:0]           per_cnt_q;

	// fifo drain side
	logic                 fifo_valid;
	logic [WORD_BITS-1:0] fifo_data;

	// pins cross into the clock domain before anything looks at them
	pin_sync #(
		.RESET_VAL (CS_N_RESET)
	) u_cs_sync (
		.clock (clock),
		.nrst  (nrst),
		.pin   (cs_n_pin),
		.level (cs_n_s)
	);

	pin_sync #(
		.RESET_VAL (SCLK_RESET)
	) u_sclk_sync (
		.clock (clock),
		.nrst  (nrst),
		.pin   (sclk_pin),
		.level (sclk_s)
	);

	// remember the last synchronised levels for edge detection
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cs_n_prev_q <= CS_N_RESET;
			sclk_prev_q <= SCLK_RESET;
		end else begin
			cs_n_prev_q <= cs_n_s;
			sclk_prev_q <= sclk_s;
		end
	end

	// edge decode; falls are ignored in shutdown so a stray clock is harmless
	wire       cs_high    = cs_n_s;
	wire       cs_fall    = cs_n_prev_q & ~cs_n_s;
	wire       active     = (state_q != ST_SHUTDOWN);
	wire       sclk_fall  = sclk_prev_q & ~sclk_s & ~cs_high & active;
	wire [4:0] fall_num   = edge_cnt_q + 5'h01;
	wire       hold_edge  = sclk_fall & (state_q == ST_ACQUIRE) & (fall_num == HOLD_EDGE);
	wire       shift_edge = sclk_fall & (fall_num >= DATA_FIRST_EDGE)
	                        & (fall_num <= DATA_LAST_EDGE);
	wire       frame_end  = sclk_fall & (state_q == ST_CONVERT) & (fall_num == FRAME_EDGES);
	wire       past_frame = sclk_fall & (fall_num > DATA_LAST_EDGE);

	// word held at the hold edge; an empty buffer yields zero and an underrun flag
	wire [WORD_BITS-1:0] held_word = fifo_valid ? fifo_data : '0;

	// buffer between the converter core and the serial port
	sample_fifo #(
		.WIDTH (WORD_BITS),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock     (clock),
		.nrst      (nrst),
		.in_valid  (sample_valid),
		.in_data   (sample_data),
		.in_ready  (sample_ready),
		.out_valid (fifo_valid),
		.out_data  (fifo_data),
		.out_ready (hold_edge)
	);

	// next state: select high beats everything, so an abort is immediate
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_SHUTDOWN: begin
				if (cs_fall)
					state_d = ST_ACQUIRE;
			end
			ST_ACQUIRE: begin
				if (hold_edge)
					state_d = ST_CONVERT;
			end
			ST_CONVERT: begin
				if (frame_end)
					state_d = ST_TRAIL;
			end
			ST_TRAIL: begin
				state_d = ST_TRAIL;
			end
		endcase
		if (cs_high)
			state_d = ST_SHUTDOWN;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			state_q <= ST_SHUTDOWN;
		else
			state_q <= state_d;
	end

	// falling edge count within the frame; saturates so long trails cannot wrap
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			edge_cnt_q <= '0;
		else if (cs_high || cs_fall)
			edge_cnt_q <= '0;
		else if (sclk_fall && edge_cnt_q != FRAME_EDGES)
			edge_cnt_q <= fall_num;
	end

	// result shift register: loaded at the hold edge, zeros shift in behind
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			shift_q <= '0;
		else if (cs_high)
			shift_q <= '0;
		else if (hold_edge)
			shift_q <= held_word;
		else if (shift_edge)
			shift_q <= {shift_q[WORD_BITS-2:0], 1'b0};
	end

	// data pin: low from select fall through the leading zeros, then the word
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			dout_o  <= 1'b0;
			dout_oe <= 1'b0;
		end else if (cs_high) begin
			dout_o  <= 1'b0;
			dout_oe <= 1'b0;
		end else if (cs_fall) begin
			dout_o  <= 1'b0;
			dout_oe <= 1'b1;
		end else if (shift_edge) begin
			dout_o  <= shift_q[WORD_BITS-1];
		end else if (past_frame) begin
			dout_o  <= 1'b0;
		end
	end

	// mode and track/hold indications follow the sequencer
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			powered_up <= 1'b0;
			holding    <= 1'b0;
			frame_done <= 1'b0;
		end else begin
			powered_up <= (state_d != ST_SHUTDOWN);
			holding    <= (state_d == ST_CONVERT) || (state_d == ST_TRAIL);
			frame_done <= frame_end & ~cs_high;
		end
	end

	// acquisition timer: runs from select fall, checked at the hold edge
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			acq_cnt_q <= '0;
		else if (state_q != ST_ACQUIRE || cs_high)
			acq_cnt_q <= '0;
		else if (acq_cnt_q != ACQ_CYCLES)
			acq_cnt_q <= acq_cnt_q + 9'h001;
	end

	// serial clock period timer between successive falling edges
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			per_cnt_q <= '0;
		else if (sclk_fall || cs_fall)
			per_cnt_q <= '0;
		else if (per_cnt_q != SCLK_MIN_CYCLES)
			per_cnt_q <= per_cnt_q + 9'h001;
	end

	// sticky supervision flags, cleared by the next select fall;
	// the controller keeps the timing, the block only reports misuse
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			acq_short <= 1'b0;
			sclk_fast <= 1'b0;
			underrun  <= 1'b0;
		end else if (cs_fall) begin
			acq_short <= 1'b0;
			sclk_fast <= 1'b0;
			underrun  <= 1'b0;
		end else begin
			// the counters lag the elapsed cycles by one, hence the minus one
			if (hold_edge && acq_cnt_q < (ACQ_CYCLES - 9'h001))
				acq_short <= 1'b1;
			if (sclk_fall && edge_cnt_q != '0 && per_cnt_q < (SCLK_MIN_CYCLES - 9'h001))
				sclk_fast <= 1'b1;
			if (hold_edge && !fifo_valid)
				underrun  <= 1'b1;
		end
	end

endmodule // serial_adc_port

//--- testbench/serial_adc_port_sva.sv
// concurrent checks on the serial converter port pins and status
`timescale 1ns/1ps
module serial_adc_port_sva (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// serial pins
	input wire logic cs_n_pin,
	input wire logic sclk_pin,
	input wire logic dout_o,
	input wire logic dout_oe,
	// status
	input wire logic powered_up,
	input wire logic holding,
	input wire logic frame_done
);
	logic [4:0] fall_hist_q;
	logic [5:0] falls_q;
	logic       trail_q;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	// recent clock falls, falls since select fall (saturating), trailing phase
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			fall_hist_q <= 5'h00;
			falls_q     <= 6'h00;
			trail_q     <= 1'b0;
		end else begin
			fall_hist_q <= {fall_hist_q[3:0], $fell(sclk_pin)};
			if ($fell(cs_n_pin))
				falls_q <= 6'h00;
			else if ($fell(sclk_pin) && !cs_n_pin && falls_q != 6'h3f)
				falls_q <= falls_q + 6'h01;
			trail_q <= frame_done | (trail_q & ~cs_n_pin);
		end
	end
	a_off_no_drive: assert property (!powered_up |-> !dout_oe)
		else $error("data driven in shutdown");
	a_off_no_hold: assert property (!powered_up |-> !holding)
		else $error("holding while shut down");
	a_fall_wakes: assert property ($fell(cs_n_pin) |-> ##[1:4] (dout_oe && powered_up))
		else $error("select fall did not wake the port");
	a_enable_low: assert property ($rose(dout_oe) |-> !dout_o)
		else $error("data enabled high");
	a_rise_aborts: assert property ($rose(cs_n_pin) |-> ##[1:4] (!dout_oe && !powered_up && !holding))
		else $error("select rise did not shut down");
	a_change_on_fall: assert property (dout_oe && $past(dout_oe) && $changed(dout_o) |-> fall_hist_q != 5'h00)
		else $error("data changed without a clock fall");
	a_hold_sixth: assert property ($rose(holding) |-> falls_q == 6'h06)
		else $error("hold not at sixth fall");
	a_frame_count: assert property (frame_done |-> falls_q == 6'h18 && holding)
		else $error("frame end not at 24th fall");
	a_done_pulse: assert property (frame_done |=> !frame_done)
		else $error("frame end pulse too long");
	a_trail_quiet: assert property (trail_q |-> !dout_o && holding && !frame_done)
		else $error("trailing clocks disturbed the port");
	c_frame: cover property (frame_done);
	c_abort: cover property ($rose(cs_n_pin) && holding && !trail_q);
	c_trail: cover property (trail_q && $fell(sclk_pin));
endmodule // serial_adc_port_sva
bind serial_adc_port serial_adc_port_sva i_serial_adc_port_sva (
	.clock(clock), .nrst(nrst), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
	.dout_o(dout_o), .dout_oe(dout_oe), .powered_up(powered_up),
	.holding(holding), .frame_done(frame_done));

//--- testbench/serial_master.sv
// serial master model: drives select and serial clock, reads data
`timescale 1ns/1ps
module serial_master (
	// clock
	input  wire logic clock,
	// serial pins
	output logic      cs_n,
	output logic      sclk,
	input  wire logic dout
);
	// clock idles low and select high outside frames
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
	end
	// one frame of n falls, half period h clocks; 20+12h clocks to the hold edge
	task automatic frame(input int n, input int h, output logic [31:0] bits);
		bits = 32'h0;
		@(posedge clock);
		#1 cs_n = 1'b0;
		repeat (20) @(posedge clock);
		for (int k = 0; k < n; k++) begin
			repeat (h) @(posedge clock);
			#1 bits = {bits[30:0], dout};
			sclk = 1'b1;
			repeat (h) @(posedge clock);
			#1 sclk = 1'b0;
		end
		repeat (h) @(posedge clock);
		#1 cs_n = 1'b1;
	endtask
endmodule // serial_master

//--- testbench/serial_adc_port_tb.sv
// self-checking bench for the serial converter port
`timescale 1ns/1ps
module serial_adc_port_tb;
	import adc_port_pkg::*;
	logic        clock = 1'b0;
	logic        nrst;
	logic        cs_n, sclk, dout_o, dout_oe, sample_valid, sample_ready;
	logic        powered_up, holding, acq_short, sclk_fast, underrun;
	wire         dout_line;
	sample_t     sample_data;
	sample_t     q[$];
	logic [15:0] rnd = 16'h194c;
	int          n_errors = 0;
	int          checked = 0;
	int          cycles = 0;
	// data line floats whenever the port lets go of it
	assign dout_line = dout_oe ? dout_o : 1'bz;
	always #2.5 clock = ~clock;
	serial_adc_port i_serial_adc_port (.clock(clock), .nrst(nrst), .cs_n_pin(cs_n),
		.sclk_pin(sclk), .dout_o(dout_o), .dout_oe(dout_oe),
		.sample_valid(sample_valid), .sample_data(sample_data),
		.sample_ready(sample_ready), .powered_up(powered_up), .holding(holding),
		.frame_done(), .acq_short(acq_short), .sclk_fast(sclk_fast),
		.underrun(underrun));
	serial_master i_serial_master (.clock(clock), .cs_n(cs_n), .sclk(sclk),
		.dout(dout_line));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic step(input int c);
		repeat (c) @(posedge clock);
		#1;
	endtask
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// hang guard: the run needs well under this many cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 90000) begin
			n_errors++;
			end_of_test();
		end
	end
	initial begin
		logic [31:0] bits;
		logic [31:0] base;
		logic        tk;
		logic        empty;
		int          n;
		int          h;
		nrst = 1'b0;
		sample_valid = 1'b0;
		sample_data = 16'h0000;
		step(20);
		nrst = 1'b1;
		check("oe after reset", dout_oe, 0);
		check("ready after reset", sample_ready, 1);
		// offer more words than fit; only those offered while ready count
		for (int i = 0; i < 34; i++) begin
			rnd = lfsr(rnd);
			sample_data = (i == 0) ? 16'hffff : rnd;
			sample_valid = 1'b1;
			tk = sample_ready;
			step(1);
			if (tk)
				q.push_back(sample_data);
		end
		sample_valid = 1'b0;
		check("words held", q.size(), 32);
		check("ready when full", sample_ready, 0);
		// frame 3 aborts after the hold edge, frame 5 clocks too fast
		for (int f = 0; f < 34; f++) begin
			rnd = lfsr(rnd);
			n = (f == 0) ? 24 : (f == 3) ? 10 : 24 + rnd[2:0];
			h = (f == 5) ? 10 : 21 + rnd[5:3];
			empty = (q.size() == 0);
			base = empty ? 32'h0 : {16'h0000, q.pop_front()};
			i_serial_master.frame(n, h, bits);
			step(5);
			check("oe after select rise", dout_oe, 0);
			check("awake after select rise", {powered_up, holding}, 0);
			check("underrun", underrun, empty);
			check("clock too fast", sclk_fast, f == 5);
			check("short acquisition", acq_short, f == 5);
			if (n >= 24)
				check("frame bits", bits, base << (n - 24));
			else
				check("aborted bits", bits, base >> (24 - n));
		end
		end_of_test();
	end
endmodule // serial_adc_port_tb
